// [hdl/swec_top.sv]
`timescale 1ns/1ps
module swec_top
    import swec_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // wake source pins, active low where named _n
    input  wire logic        pwrbtn_n,
    input  wire logic        pcie_wake_n,
    input  wire logic        wdt_pwrbtn,
    input  wire logic        gen_wake_n,
    input  wire logic        rtc_alarm,
    input  wire logic        pme_n,
    input  wire logic        pme_dev_wake_en,
    input  wire logic        lan_wake,
    input  wire logic        usb_wake,
    // sleep state pins, active low
    input  wire logic        sus_s3_n,
    input  wire logic        sus_s4_n,
    input  wire logic        sus_s5_n,
    // wake request and interrupt
    output      logic        resume_req,
    output      logic        irq,
    // capability straps: enable high means pin pulled to ground
    output      logic [3:0]  pulldown_capability_strap_o,
    output      logic [3:0]  pulldown_capability_strap_oe,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers

    localparam int NPIN = 12;

    logic [NPIN-1:0] raw_pins;
    logic [NPIN-1:0] sync_pins;

    // idle levels: active-low pins rest high
    localparam logic [NPIN-1:0] PIN_IDLE = 12'he2b;

    assign raw_pins = {sus_s5_n, sus_s4_n, sus_s3_n, pme_dev_wake_en, usb_wake,
                       lan_wake, pme_n, rtc_alarm, gen_wake_n, wdt_pwrbtn,
                       pcie_wake_n, pwrbtn_n};

    swec_sync #(
        .WIDTH     (NPIN),
        .RESET_VAL (PIN_IDLE)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (raw_pins),
        .q       (sync_pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sleep state decode

    swec_sleep_e sleep_state;
    logic        suspended;

    always_comb
    begin
        if (swec_active_low(sync_pins[11]))
            sleep_state = SWEC_S5;
        else if (swec_active_low(sync_pins[10]))
            sleep_state = SWEC_S4;
        else if (swec_active_low(sync_pins[9]))
            sleep_state = SWEC_S3;
        else
            sleep_state = SWEC_S0;
    end

    assign suspended = (sleep_state != SWEC_S0);

    ////////////////////////////////////////////////////////////////////////////
    // source qualification

    logic [3:0]              ctrl;
    logic [SWEC_NUM_SRC-1:0] src_level;
    logic [SWEC_NUM_SRC-1:0] src_rise;
    logic [SWEC_NUM_SRC-1:0] qual;

    always_comb
    begin
        src_level = '0;
        src_level[SRC_PWRBTN] = swec_active_low(sync_pins[0]);
        src_level[SRC_PCIE]   = swec_active_low(sync_pins[1]);
        src_level[SRC_WDT]    = sync_pins[2];
        src_level[SRC_GWAKE]  = swec_active_low(sync_pins[3]);
        src_level[SRC_RTC]    = sync_pins[4];
        src_level[SRC_PME]    = swec_active_low(sync_pins[5]);
        src_level[SRC_LAN]    = sync_pins[6];
        src_level[SRC_USB]    = sync_pins[7];
    end

    swec_edge #(
        .WIDTH (SWEC_NUM_SRC)
    ) u_edge (
        .clk     (clk),
        .reset_n (reset_n),
        .level   (src_level),
        .rise    (src_rise)
    );

    always_comb
    begin
        qual = '0;
        qual[SRC_PWRBTN] = src_level[SRC_PWRBTN] && suspended;
        qual[SRC_PCIE]   = src_level[SRC_PCIE] && suspended;
        qual[SRC_WDT]    = src_level[SRC_WDT] && suspended;
        qual[SRC_GWAKE]  = src_level[SRC_GWAKE] && (sleep_state == SWEC_S3);
        qual[SRC_RTC]    = src_level[SRC_RTC] && suspended && ctrl[CTRL_RTC_EN];
        qual[SRC_PME]    = src_level[SRC_PME] && suspended
                           && (ctrl[CTRL_PME_EN] || sync_pins[8]);
        qual[SRC_LAN]    = src_level[SRC_LAN] && suspended && ctrl[CTRL_WOL_EN];
        qual[SRC_USB]    = src_level[SRC_USB] && ctrl[CTRL_USB_EN]
                           && ((sleep_state == SWEC_S3) || (sleep_state == SWEC_S4));
    end

    ////////////////////////////////////////////////////////////////////////////
    // latched resume request

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            resume_req <= 1'b0;
        else if (!suspended)
            resume_req <= 1'b0;
        else if (|qual)
            resume_req <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // straps

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pulldown_capability_strap_o  <= 4'h0;
            pulldown_capability_strap_oe <= 4'h0;
        end
        else
        begin
            pulldown_capability_strap_o  <= 4'h0;
            pulldown_capability_strap_oe <= CAPS_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    logic [SWEC_NUM_SRC-1:0] status;
    logic [SWEC_NUM_SRC-1:0] mask;
    logic                    aw_held;
    logic                    w_held;
    logic [7:0]              aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    wr_fire;
    logic [SWEC_NUM_SRC-1:0] clr_bits;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[7:2] == REG_CTRL[7:2] || aw_addr[7:2] == REG_STATUS[7:2]
                             || aw_addr[7:2] == REG_MASK[7:2]) ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl <= CTRL_RESET;
            mask <= MASK_RESET;
        end
        else if (wr_fire && w_strb[0])
        begin
            if (aw_addr[7:2] == REG_CTRL[7:2])
                ctrl <= w_data[3:0];
            if (aw_addr[7:2] == REG_MASK[7:2])
                mask <= w_data[7:0];
        end
    end

    assign clr_bits = (wr_fire && w_strb[0] && aw_addr[7:2] == REG_STATUS[7:2])
                      ? w_data[7:0] : '0;

    // a new event wins over a simultaneous write-one clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            status <= '0;
        else
            status <= (status & ~clr_bits) | (src_rise & qual);
    end

    assign irq = |(status & mask);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= AXI_OKAY;
            case (s_axi_araddr[7:2])
                REG_CTRL[7:2]:   s_axi_rdata <= {28'h0, ctrl};
                REG_STATE[7:2]:  s_axi_rdata <= {20'h0, resume_req, src_level,
                                                 1'b0, 2'(sleep_state)};
                REG_STATUS[7:2]: s_axi_rdata <= {24'h0, status};
                REG_MASK[7:2]:   s_axi_rdata <= {24'h0, mask};
                REG_CAPS[7:2]:   s_axi_rdata <= {28'h0, CAPS_VALUE};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= AXI_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    assign s_axi_arready = !s_axi_rvalid;

endmodule

// [hdl/swec_pkg.sv]
package swec_pkg;

    localparam int SWEC_NUM_SRC = 8;

    // source bit positions
    localparam int SRC_PWRBTN = 0;
    localparam int SRC_PCIE   = 1;
    localparam int SRC_WDT    = 2;
    localparam int SRC_GWAKE  = 3;
    localparam int SRC_RTC    = 4;
    localparam int SRC_PME    = 5;
    localparam int SRC_LAN    = 6;
    localparam int SRC_USB    = 7;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATE  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MASK   = 8'h0c;
    localparam logic [7:0] REG_CAPS   = 8'h10;

    // control bit positions
    localparam int CTRL_RTC_EN = 0;
    localparam int CTRL_PME_EN = 1;
    localparam int CTRL_WOL_EN = 2;
    localparam int CTRL_USB_EN = 3;

    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [3:0] CAPS_VALUE = 4'h0;

    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [1:0] {SWEC_S0, SWEC_S3, SWEC_S4, SWEC_S5} swec_sleep_e;

    function automatic logic swec_active_low(input logic pin_n);
        return ~pin_n;
    endfunction

endpackage

// [hdl/swec_sync.sv]
`timescale 1ns/1ps
module swec_sync
    import swec_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // data
    input  wire logic [WIDTH-1:0] d,
    output      logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// [hdl/swec_edge.sv]
`timescale 1ns/1ps
module swec_edge
    import swec_pkg::*;
#(
    parameter int WIDTH = 1
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // levels in, rising-edge pulses out
    input  wire logic [WIDTH-1:0] level,
    output      logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] last;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            last <= '0;
        else
            last <= level;
    end

    assign rise = level & ~last;
endmodule

// [tb/swec_top_sva.sv]
`timescale 1ns/1ps
module swec_top_sva
    import swec_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // wake pins
    input wire logic       pwrbtn_n,
    input wire logic       pcie_wake_n,
    input wire logic       wdt_pwrbtn,
    input wire logic       gen_wake_n,
    input wire logic       rtc_alarm,
    input wire logic       pme_n,
    input wire logic       lan_wake,
    input wire logic       usb_wake,
    input wire logic       sus_s3_n,
    input wire logic       sus_s4_n,
    input wire logic       sus_s5_n,
    // outputs
    input wire logic       resume_req,
    input wire logic [3:0] pulldown_capability_strap_o,
    input wire logic [3:0] pulldown_capability_strap_oe
);
////////////////////////////////////////
logic       susp;
logic       s3;
logic [7:0] pins;
assign susp = !(sus_s3_n && sus_s4_n && sus_s5_n);
assign s3   = !sus_s3_n && sus_s4_n && sus_s5_n;
assign pins = {usb_wake, lan_wake, !pme_n, rtc_alarm, !gen_wake_n, wdt_pwrbtn,
               !pcie_wake_n, !pwrbtn_n};
default clocking cb @(posedge clk); endclocking
default disable iff (!reset_n);
////////////////////////////////////////
a_btn_wakes: assert property ((susp && pins[SRC_PWRBTN])[*5] |=> resume_req)
    else $error("no resume after power button");
a_pcie_wakes: assert property ((susp && pins[SRC_PCIE])[*5] |=> resume_req)
    else $error("no resume after pcie wake");
a_gwake_s3: assert property ((s3 && pins[SRC_GWAKE])[*5] |=> resume_req)
    else $error("no resume after generic wake");
a_gwake_deep: assert property ((!sus_s5_n && !resume_req && pins == 8'h08)[*5]
    |=> !resume_req)
    else $error("generic wake resumed from s5");
a_awake_clears: assert property ((!susp)[*4] |=> !resume_req)
    else $error("resume request not cleared when awake");
a_req_held: assert property ((susp && resume_req)[*4] |=> resume_req)
    else $error("resume request dropped while suspended");
a_sync_two: assert property (pins == 8'h01 && $past(pins) == 8'h00
    && $past(pins, 2) == 8'h00 && !resume_req |-> ##2 !resume_req)
    else $error("wake input not synchronised");
a_straps_open: assert property (pulldown_capability_strap_o == 4'h0
    && pulldown_capability_strap_oe == CAPS_VALUE)
    else $error("strap outputs wrong");
endmodule

// [tb/swec_carrier.sv]
`timescale 1ns/1ps
module swec_carrier
    import swec_pkg::*;
(
    // bench commands
    input  wire logic        clk,
    input  wire logic [7:0]  ev,
    input  wire swec_sleep_e state,
    // pins towards the module
    output logic             pwrbtn_n,
    output logic             pcie_wake_n,
    output logic             wdt_pwrbtn,
    output logic             gen_wake_n,
    output logic             rtc_alarm,
    output logic             pme_n,
    output logic             lan_wake,
    output logic             usb_wake,
    output logic             sus_s3_n,
    output logic             sus_s4_n,
    output logic             sus_s5_n,
    // capability straps
    input  wire logic [3:0]  strap_o,
    input  wire logic [3:0]  strap_oe,
    output logic [3:0]       strap_seen
);
logic [7:0] ev_q = 8'h00;
logic       usb_pwr;
always_ff @(posedge clk) ev_q <= ev;
// usb kept on the standby supply so its wake survives suspend
assign usb_pwr     = 1'b1;
assign pwrbtn_n    = !ev_q[SRC_PWRBTN];
assign pcie_wake_n = !ev_q[SRC_PCIE];
assign wdt_pwrbtn  = ev_q[SRC_WDT];
assign gen_wake_n  = !ev_q[SRC_GWAKE];
assign rtc_alarm   = ev_q[SRC_RTC];
assign pme_n       = !ev_q[SRC_PME];
assign lan_wake    = ev_q[SRC_LAN];
assign usb_wake    = ev_q[SRC_USB] && usb_pwr;
assign sus_s3_n    = (state == SWEC_S0);
assign sus_s4_n    = !(state inside {SWEC_S4, SWEC_S5});
assign sus_s5_n    = (state != SWEC_S5);
// an open strap reads high through the carrier pull-up
always_ff @(posedge clk) strap_seen <= ~strap_oe | strap_o;
endmodule

// [tb/suspend_wake_event_combiner_tb_top.sv]
`timescale 1ns/1ps
module suspend_wake_event_combiner_tb_top
    import swec_pkg::*;
;
logic        clk = 1'b0;
logic        reset_n = 1'b0;
logic [7:0]  ev = 8'h00;
logic        pme_dev_wake_en = 1'b0;
swec_sleep_e state = SWEC_S0;
logic        pwrbtn_n, pcie_wake_n, wdt_pwrbtn, gen_wake_n, rtc_alarm, pme_n;
logic        lan_wake, usb_wake, sus_s3_n, sus_s4_n, sus_s5_n, resume_req, irq;
logic [3:0]  pulldown_capability_strap_o, pulldown_capability_strap_oe, strap_seen;
logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0;
logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0]  s_axi_bresp, s_axi_rresp;
logic [31:0] s_axi_rdata;
logic        exp;
logic [3:0]  ce;
int          fails = 0;
int          n_checks = 0;
int          cycles = 0;
////////////////////////////////////////
swec_top u_dut (.clk, .reset_n, .pwrbtn_n, .pcie_wake_n, .wdt_pwrbtn, .gen_wake_n,
    .rtc_alarm, .pme_n, .pme_dev_wake_en, .lan_wake, .usb_wake, .sus_s3_n, .sus_s4_n,
    .sus_s5_n, .resume_req, .irq, .pulldown_capability_strap_o,
    .pulldown_capability_strap_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
swec_carrier u_carrier (.clk, .ev, .state, .pwrbtn_n, .pcie_wake_n, .wdt_pwrbtn,
    .gen_wake_n, .rtc_alarm, .pme_n, .lan_wake, .usb_wake, .sus_s3_n, .sus_s4_n,
    .sus_s5_n, .strap_o(pulldown_capability_strap_o),
    .strap_oe(pulldown_capability_strap_oe), .strap_seen);
////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
        fails++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
endtask
task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
////////////////////////////////////////
initial
begin
    forever #2 clk = ~clk;
end
always @(posedge clk)
begin
    cycles++;
    if (cycles == 30000)
    begin
        fails++;
        conclude();
    end
end
initial
begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd(REG_CTRL, 32'h0, AXI_OKAY);
    rd(REG_MASK, 32'h0, AXI_OKAY);
    rd(REG_STATE, 32'h0, AXI_OKAY);
    rd(REG_CAPS, 32'h0, AXI_OKAY);
    rd(8'h14, 32'h0, AXI_SLVERR);
    wr(8'h14, 32'hf, AXI_SLVERR);
    chk("strap", 32'hf, {28'h0, strap_seen});
    for (int en = 0; en < 5; en++)
    begin
        // no enable first, then one enable at a time, so a swapped enable bit shows up
        ce = (en == 0) ? 4'h0 : 4'h1 << (en - 1);
        wr(REG_CTRL, {28'h0, ce}, AXI_OKAY);
        rd(REG_CTRL, {28'h0, ce}, AXI_OKAY);
        for (int st = 1; st < 4; st++)
        begin
            for (int s = 0; s < 9; s++)
            begin
                state <= swec_sleep_e'(st);
                repeat (6) @(posedge clk);
                ev <= (s == 8) ? 8'h20 : 8'h01 << s;
                pme_dev_wake_en <= (s == 8);
                repeat (8) @(posedge clk);
                exp = s < 3 || (s == 3 && st == 1) || (s == 4 && ce[CTRL_RTC_EN])
                      || (s == 5 && ce[CTRL_PME_EN]) || (s == 6 && ce[CTRL_WOL_EN])
                      || (s == 7 && ce[CTRL_USB_EN] && st < 3) || s == 8;
                #1;
                chk("resume_req", {31'h0, exp}, {31'h0, resume_req});
                @(posedge clk);
                ev <= 8'h00;
                pme_dev_wake_en <= 1'b0;
                state <= SWEC_S0;
                repeat (6) @(posedge clk);
                #1;
                chk("resume_clear", 32'h0, {31'h0, resume_req});
                @(posedge clk);
            end
        end
    end
    state <= SWEC_S4;
    repeat (4) @(posedge clk);
    rd(REG_STATE, 32'h2, AXI_OKAY);
    state <= SWEC_S0;
    rd(REG_STATUS, 32'hff, AXI_OKAY);
    wr(REG_MASK, 32'h0, AXI_OKAY);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    wr(REG_MASK, 32'h1, AXI_OKAY);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    wr(REG_STATUS, 32'hff, AXI_OKAY);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    rd(REG_STATUS, 32'h0, AXI_OKAY);
    conclude();
end
endmodule
////////////////////////////////////////
bind swec_top swec_top_sva u_sva (.clk, .reset_n, .pwrbtn_n, .pcie_wake_n, .wdt_pwrbtn,
    .gen_wake_n, .rtc_alarm, .pme_n, .lan_wake, .usb_wake, .sus_s3_n, .sus_s4_n,
    .sus_s5_n, .resume_req, .pulldown_capability_strap_o, .pulldown_capability_strap_oe);
